//--- hdl/twc_device.sv
// Device end of the two-wire command port.
// Notes on behaviour
// - Latch straps at reset rise; select bus mode.
// - Pull strap a up, strap b down.
// - After reset straps become plain outputs.
// - Controller holds clock high through reset release.
// - Controller sends no start near release.
// - Data falling with clock high starts.
// - Control word MSB first, sampled rising.
// - Acknowledge own address from next falling edge.
// - Address picked by address select level.
// - Acknowledge each written byte one cycle.
// - At most eight bytes: command, seven arguments.
// - Read bytes shift out on falling edges.
// - Controller acknowledges every read byte but the last.
// - Missing acknowledge ends read, releases data.
// - At most sixteen bytes from response buffer.
// - Data rising with clock high stops.
// - Controller starts on request without checking clear to send.
// - Reset disables bus and clears state.
`timescale 1ns/100ps
module twc_device
(
	input  wire logic                CORE_CLK,
	input  wire logic                SRST,
	twc_if.device                    PINS,
	input  wire logic [8*16-1:0]     RESP_DATA,
	input  wire logic                GPO_A,
	input  wire logic                GPO_B,
	output logic      [1:0]          BUS_MODE,
	output logic      [8*8-1:0]      CMD_DATA,
	output logic      [3:0]          CMD_COUNT,
	output logic                     CMD_VALID
);
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_WRITE,
		ST_READ,
		ST_MACK,
		ST_IGNORE
	} twc_state_t;

	logic [1:0]   scl_s_q;
	logic [1:0]   sda_s_q;
	logic [1:0]   rstn_s_q;
	logic         scl_q;
	logic         sda_q;
	logic         rstn_q;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_ev;
	logic         stop_ev;
	logic         rst_rise;
	logic         in_reset;
	twc_state_t   state_q;
	logic [7:0]   shift_q;
	logic [2:0]   bit_q;
	logic         rd_q;
	logic         ack_drive_q;
	logic         data_drive_q;
	logic [4:0]   byte_q;
	logic [1:0]   strap_q;
	logic [1:0]   strap_s_a_q;
	logic [1:0]   strap_s_b_q;
	logic [1:0]   asel_s_q;
	logic         ack_pending_q;
	logic         cmd_open_q;

	// Pins come from outside the clock domain and pass two flip-flops first.
	always_ff @(posedge CORE_CLK)
	begin
		scl_s_q     <= {scl_s_q[0], PINS.serial_clock_pin};
		sda_s_q     <= {sda_s_q[0], PINS.serial_data_pin};
		rstn_s_q    <= {rstn_s_q[0], PINS.chip_reset_n};
		strap_s_a_q <= {strap_s_a_q[0], PINS.mode_strap_a_out};
		strap_s_b_q <= {strap_s_b_q[0], PINS.mode_strap_b_irq};
		asel_s_q    <= {asel_s_q[0], PINS.address_select_pin};
		scl_q       <= scl_s_q[1];
		sda_q       <= sda_s_q[1];
		rstn_q      <= rstn_s_q[1];
	end

	assign scl_rise = scl_s_q[1] && !scl_q;
	assign scl_fall = !scl_s_q[1] && scl_q;
	// Edges of data while the clock stays high are framing only.
	assign start_ev = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
	assign stop_ev  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
	assign rst_rise = rstn_s_q[1] && !rstn_q;
	assign in_reset = SRST || !rstn_s_q[1];

	// Strap latch on the reset release; only two-wire runs the engine.
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
			strap_q <= twc_pkg::STRAP_THREE;
		else if (rst_rise)
			strap_q <= {strap_s_a_q[1], strap_s_b_q[1]};
	end

	always_comb
	begin
		unique case (strap_q)
			twc_pkg::STRAP_TWO_WIRE: BUS_MODE = twc_pkg::TWC_MODE_TWO_WIRE;
			twc_pkg::STRAP_SPI:      BUS_MODE = twc_pkg::TWC_MODE_SPI;
			twc_pkg::STRAP_THREE:    BUS_MODE = twc_pkg::TWC_MODE_THREE_WIRE;
			default:                 BUS_MODE = twc_pkg::TWC_MODE_NONE;
		endcase
	end

	// In reset the drivers let go so the pad pulls set the defaults; a
	// drive here would hide the pad pulls, as the controller leaves both straps undriven.
	always_comb
	begin
		PINS.strap_a_d_oe = !in_reset;
		PINS.strap_b_d_oe = !in_reset;
		PINS.strap_a_d_o  = GPO_A;
		PINS.strap_b_d_o  = GPO_B;
	end

	// Protocol engine; reset of the chip holds it idle.
	always_ff @(posedge CORE_CLK)
	begin
		if (in_reset || BUS_MODE != twc_pkg::TWC_MODE_TWO_WIRE)
		begin
			state_q       <= ST_IDLE;
			shift_q       <= 8'h00;
			bit_q         <= 3'h0;
			rd_q          <= 1'b0;
			ack_drive_q   <= 1'b0;
			data_drive_q  <= 1'b0;
			byte_q        <= 5'h00;
			ack_pending_q <= 1'b0;
		end
		else if (start_ev)
		begin
			state_q      <= ST_ADDR;
			bit_q        <= 3'h0;
			byte_q       <= 5'h00;
			ack_drive_q  <= 1'b0;
			data_drive_q <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_q      <= ST_IDLE;
			ack_drive_q  <= 1'b0;
			data_drive_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE, ST_IGNORE:
					data_drive_q <= 1'b0;
				ST_ADDR, ST_WRITE:
				begin
					if (scl_rise)
					begin
						shift_q <= {shift_q[6:0], sda_q};
						bit_q   <= bit_q + 3'h1;
						if (bit_q == 3'h7)
							ack_pending_q <= 1'b1;
					end
					else if (scl_fall && ack_pending_q)
					begin
						ack_pending_q <= 1'b0;
						if (state_q == ST_ADDR)
						begin
							if (shift_q[7:1] == (asel_s_q[1] ?
								twc_pkg::ADDR_SEL_HIGH :
								twc_pkg::ADDR_SEL_LOW))
							begin
								rd_q        <= shift_q[0];
								ack_drive_q <= 1'b1;
								state_q     <= ST_ACK;
							end
							else
								state_q <= ST_IGNORE;
						end
						else if (byte_q < 5'(twc_pkg::WRITE_BYTES_MAX))
						begin
							ack_drive_q <= 1'b1;
							byte_q      <= byte_q + 5'h01;
							state_q     <= ST_ACK;
						end
						else
							state_q <= ST_IGNORE;
					end
				end
				ST_ACK:
					if (scl_fall)
					begin
						ack_drive_q <= 1'b0;
						bit_q       <= 3'h0;
						if (rd_q)
						begin
							shift_q      <= RESP_DATA[8*16-1-8*byte_q[3:0] -: 8];
							data_drive_q <= 1'b1;
							state_q      <= ST_READ;
						end
						else
							state_q <= ST_WRITE;
					end
				ST_READ:
					if (scl_fall)
					begin
						shift_q <= {shift_q[6:0], 1'b1};
						bit_q   <= bit_q + 3'h1;
						if (bit_q == 3'h7)
						begin
							data_drive_q <= 1'b0;
							byte_q       <= byte_q + 5'h01;
							state_q      <= ST_MACK;
						end
					end
				ST_MACK:
					if (scl_rise)
					begin
						if (sda_q || byte_q >= 5'(twc_pkg::READ_BYTES_MAX))
							state_q <= ST_IGNORE;
						else
							state_q <= ST_ACK;
					end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Device only pulls low: ack, or a zero data bit.
	assign PINS.sda_d_o  = 1'b0;
	assign PINS.sda_d_oe = ack_drive_q || (data_drive_q && !shift_q[7]);

	// Written bytes collect here and are handed over on the stop or a repeated start.
	always_ff @(posedge CORE_CLK)
	begin
		if (in_reset)
		begin
			CMD_DATA   <= '0;
			CMD_COUNT  <= 4'h0;
			CMD_VALID  <= 1'b0;
			cmd_open_q <= 1'b0;
		end
		else
		begin
			CMD_VALID <= 1'b0;
			if (state_q == ST_ADDR && scl_fall && ack_pending_q)
			begin
				cmd_open_q <= 1'b1;
				CMD_COUNT  <= 4'h0;
			end
			if (state_q == ST_WRITE && scl_fall && ack_pending_q &&
				byte_q < 5'(twc_pkg::WRITE_BYTES_MAX))
			begin
				CMD_DATA[8*8-1-8*byte_q[2:0] -: 8] <= shift_q;
				CMD_COUNT <= byte_q[3:0] + 4'h1;
			end
			if ((stop_ev || start_ev) && cmd_open_q)
			begin
				cmd_open_q <= 1'b0;
				CMD_VALID  <= !rd_q && CMD_COUNT != 4'h0;
			end
		end
	end
endmodule

//--- hdl/twc_pkg.sv
// Package with the shared constants and types of the two-wire command port.
package twc_pkg;

	// Seven-bit device addresses picked by the address select pin.
	localparam logic [6:0] ADDR_SEL_LOW  = 7'h11;
	localparam logic [6:0] ADDR_SEL_HIGH = 7'h63;

	// Strap codes, strap a in bit 1 and strap b in bit 0.
	localparam logic [1:0] STRAP_TWO_WIRE = 2'h2;
	localparam logic [1:0] STRAP_SPI      = 2'h3;
	localparam logic [1:0] STRAP_THREE    = 2'h0;

	// Transfer limits per transaction.
	localparam int WRITE_BYTES_MAX = 8;
	localparam int READ_BYTES_MAX  = 16;

	// Serial clock divider of the controller end, in core cycles per tick; a serial clock period is three ticks.
	localparam int HALF_PERIOD_CYC = 40;

	// Guard between strap setup and reset release, in ns and cycles.
	localparam int START_GUARD_NS  = 300;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int START_GUARD_CYC =
		(START_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Bus mode latched from the straps.
	typedef enum logic [1:0]
	{
		TWC_MODE_TWO_WIRE,
		TWC_MODE_SPI,
		TWC_MODE_THREE_WIRE,
		TWC_MODE_NONE
	} twc_mode_t;

endpackage

//--- hdl/twc_if.sv
// Interface carrying the pins between the controller and the device.
`timescale 1ns/100ps
interface twc_if;
	logic chip_reset_n;
	logic scl_m_o;
	logic scl_m_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic strap_a_m_o;
	logic strap_a_m_oe;
	logic strap_b_m_o;
	logic strap_b_m_oe;
	logic strap_a_d_o;
	logic strap_a_d_oe;
	logic strap_b_d_o;
	logic strap_b_d_oe;
	logic address_select_pin;

	// Wire levels resolved from the enables, with pull-ups on the bus.
	logic serial_clock_pin;
	logic serial_data_pin;
	logic mode_strap_a_out;
	logic mode_strap_b_irq;
	assign serial_clock_pin = !(scl_m_oe && !scl_m_o);
	assign serial_data_pin  = !((sda_m_oe && !sda_m_o) ||
		(sda_d_oe && !sda_d_o));
	assign mode_strap_a_out = strap_a_m_oe ? strap_a_m_o :
		(strap_a_d_oe ? strap_a_d_o : 1'b1);
	assign mode_strap_b_irq = strap_b_m_oe ? strap_b_m_o :
		(strap_b_d_oe ? strap_b_d_o : 1'b0);

	modport device
	(
		input  chip_reset_n,
		input  serial_clock_pin,
		input  serial_data_pin,
		input  mode_strap_a_out,
		input  mode_strap_b_irq,
		input  address_select_pin,
		output sda_d_o,
		output sda_d_oe,
		output strap_a_d_o,
		output strap_a_d_oe,
		output strap_b_d_o,
		output strap_b_d_oe
	);

	modport controller
	(
		input  serial_clock_pin,
		input  serial_data_pin,
		output chip_reset_n,
		output scl_m_o,
		output scl_m_oe,
		output sda_m_o,
		output sda_m_oe,
		output strap_a_m_o,
		output strap_a_m_oe,
		output strap_b_m_o,
		output strap_b_m_oe,
		output address_select_pin
	);
endinterface

//--- hdl/twc_controller.sv
// Controller end: straps, reset release and whole transactions.
`timescale 1ns/100ps
module twc_controller
(
	input  wire logic                CORE_CLK,
	input  wire logic                SRST,
	twc_if.controller                PINS,
	input  wire logic                ADDR_SEL,
	input  wire logic                REQ,
	input  wire logic                REQ_READ,
	input  wire logic [4:0]          REQ_LEN,
	input  wire logic [8*8-1:0]      WR_DATA,
	output logic                     BUSY,
	output logic                     DONE,
	output logic      [8*16-1:0]     RD_DATA,
	output logic                     NACKED
);
	typedef enum logic [2:0]
	{
		CS_RESET,
		CS_IDLE,
		CS_START,
		CS_BITS,
		CS_STOP
	} twc_cstate_t;

	twc_cstate_t cs_q;
	logic [7:0]  div_q;
	logic        phase_q;
	logic [1:0]  sda_s_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_q;
	logic [4:0]  byte_q;
	logic [4:0]  len_q;
	logic        rd_q;
	logic        ctl_q;
	logic        scl_q;
	logic        sda_q;
	logic        tick;
	logic [8*8-1:0] wr_q;

	assign tick = div_q == 8'(twc_pkg::HALF_PERIOD_CYC - 1);

	// Data pin sampled by two flip-flops before use.
	always_ff @(posedge CORE_CLK)
		sda_s_q <= {sda_s_q[0], PINS.serial_data_pin};

	// Tick divider makes the serial clock, three ticks per period.
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// Straps: two-wire, clock held high across release.
	assign PINS.strap_a_m_o        = 1'b1;
	assign PINS.strap_a_m_oe       = 1'b0;
	assign PINS.strap_b_m_o        = 1'b0;
	assign PINS.strap_b_m_oe       = 1'b0;
	assign PINS.address_select_pin = ADDR_SEL;
	assign PINS.scl_m_o            = 1'b0;
	assign PINS.scl_m_oe           = !scl_q;
	assign PINS.sda_m_o            = 1'b0;
	assign PINS.sda_m_oe           = !sda_q;
	assign BUSY = cs_q != CS_IDLE;

	// Each bit takes three divider ticks: set data, clock high, clock low.
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			cs_q              <= CS_RESET;
			PINS.chip_reset_n <= 1'b0;
			scl_q             <= 1'b1;
			sda_q             <= 1'b1;
			phase_q           <= 1'b0;
			shift_q           <= 8'h00;
			bit_q             <= 4'h0;
			byte_q            <= 5'h00;
			len_q             <= 5'h00;
			rd_q              <= 1'b0;
			ctl_q             <= 1'b0;
			wr_q              <= '0;
			RD_DATA           <= '0;
			DONE              <= 1'b0;
			NACKED            <= 1'b0;
		end
		else
		begin
			DONE <= 1'b0;
			unique case (cs_q)
				CS_RESET:
					if (tick)
					begin
						PINS.chip_reset_n <= 1'b1;
						cs_q <= CS_IDLE;
					end
				CS_IDLE:
					if (REQ && tick)
					begin
						// Caller keeps to limits and polls ready first.
						rd_q    <= REQ_READ;
						len_q   <= REQ_LEN;
						wr_q    <= WR_DATA;
						shift_q <= {twc_pkg::ADDR_SEL_LOW ^ (ADDR_SEL ?
							(twc_pkg::ADDR_SEL_LOW ^ twc_pkg::ADDR_SEL_HIGH) :
							7'h00), REQ_READ};
						sda_q   <= 1'b0;
						ctl_q   <= 1'b1;
						byte_q  <= 5'h00;
						bit_q   <= 4'h0;
						NACKED  <= 1'b0;
						cs_q    <= CS_START;
					end
				CS_START:
					if (tick)
					begin
						scl_q   <= 1'b0;
						phase_q <= 1'b0;
						cs_q    <= CS_BITS;
					end
				CS_BITS:
					if (tick)
					begin
						phase_q <= !phase_q;
						if (!phase_q)
						begin
							// Clock low: present a bit or the ack slot.
							if (bit_q < 4'h8)
								sda_q <= (rd_q && !ctl_q) ? 1'b1 : shift_q[7];
							else
								sda_q <= !(rd_q && !ctl_q &&
									byte_q + 5'h01 < len_q);
						end
						else if (!scl_q)
						begin
							scl_q <= 1'b1;
							phase_q <= 1'b1;
							if (bit_q < 4'h8)
								shift_q <= {shift_q[6:0], sda_s_q[1]};
						end
						else
						begin
							scl_q <= 1'b0;
							phase_q <= 1'b0;
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h8)
							begin
								bit_q <= 4'h0;
								ctl_q <= 1'b0;
								if (rd_q && !ctl_q)
									RD_DATA[8*16-1-8*byte_q[3:0] -: 8]
										<= shift_q;
								if (!ctl_q)
									byte_q <= byte_q + 5'h01;
								if (sda_s_q[1] && (ctl_q || !rd_q))
									NACKED <= 1'b1;
								if ((!ctl_q && byte_q + 5'h01 >= len_q) ||
									(sda_s_q[1] && (ctl_q || !rd_q)))
								begin
									sda_q <= 1'b0;
									cs_q  <= CS_STOP;
								end
								else if (!rd_q)
									shift_q <= wr_q[8*8-1-8*(ctl_q ? 3'h0 :
										3'(byte_q + 5'h01)) -: 8];
							end
						end
					end
				CS_STOP:
					if (tick)
					begin
						if (!scl_q)
							scl_q <= 1'b1;
						else
						begin
							sda_q <= 1'b1;
							DONE  <= 1'b1;
							cs_q  <= CS_IDLE;
						end
					end
				default:
					cs_q <= CS_IDLE;
			endcase
		end
	end
endmodule

//--- bench/twc_properties.sv
// Checker watching the pins between the controller and device ends.
`timescale 1ns/100ps
module twc_properties
(
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic chip_reset_n,
	input wire logic serial_clock_pin,
	input wire logic serial_data_pin,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	input wire logic strap_a_d_oe,
	input wire logic strap_b_d_oe,
	input wire logic address_select_pin
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic [7:0] ctl_q;
	logic       start;
	logic       stop;
	logic       rise;
	logic [6:0] own;

	// Bus events as the core clock sees them, one cycle of history.
	assign start = scl_q && serial_clock_pin && sda_q && !serial_data_pin;
	assign stop  = scl_q && serial_clock_pin && !sda_q && serial_data_pin;
	assign rise  = serial_clock_pin && !scl_q;
	assign own   = address_select_pin ? twc_pkg::ADDR_SEL_HIGH :
		twc_pkg::ADDR_SEL_LOW;

	// Pin history for edge detection.
	always_ff @(posedge CORE_CLK)
	begin
		scl_q <= serial_clock_pin;
		sda_q <= serial_data_pin;
	end

	// Bit count parks at nine so data bytes never disturb the control word.
	always_ff @(posedge CORE_CLK)
	begin
		if (SRST || start)
			bit_q <= 4'h0;
		else if (rise && bit_q < 4'h9)
			bit_q <= bit_q + 4'h1;
	end

	// Control word shifted in on rising clock edges.
	always_ff @(posedge CORE_CLK)
	begin
		if (rise && bit_q < 4'h8)
			ctl_q <= {ctl_q[6:0], serial_data_pin};
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (SRST);

	property p_strap_free;
		!chip_reset_n [*4] |-> !strap_a_d_oe && !strap_b_d_oe;
	endproperty
	property p_bus_off;
		!chip_reset_n [*4] |-> !sda_d_oe;
	endproperty
	property p_gpo_on;
		$rose(chip_reset_n) |-> ##[1:8] (strap_a_d_oe && strap_b_d_oe);
	endproperty
	property p_quiet_high;
		scl_q && serial_clock_pin |-> $stable(sda_d_oe);
	endproperty
	property p_addr_ack;
		rise && bit_q == 4'h8 |->
			(sda_d_oe && !sda_d_o) == (ctl_q[7:1] == own);
	endproperty
	property p_foreign;
		bit_q == 4'h9 && ctl_q[7:1] != own |-> !sda_d_oe;
	endproperty
	property p_ack_release;
		rise && bit_q == 4'h8 && !ctl_q[0] |-> ##[80:120] !sda_d_oe;
	endproperty
	property p_stop_idle;
		stop |=> !sda_d_oe [*8];
	endproperty

	a_strap_free: assert property (p_strap_free)
		else $error("strap driven during reset");
	a_bus_off: assert property (p_bus_off)
		else $error("data driven during reset");
	a_gpo_on: assert property (p_gpo_on)
		else $error("straps not driven after reset");
	a_quiet_high: assert property (p_quiet_high)
		else $error("data drive changed with clock high");
	a_addr_ack: assert property (p_addr_ack)
		else $error("address acknowledge wrong");
	a_foreign: assert property (p_foreign)
		else $error("foreign address drove data");
	a_ack_release: assert property (p_ack_release)
		else $error("acknowledge not released");
	a_stop_idle: assert property (p_stop_idle)
		else $error("data driven after stop");

	c_read: cover property (rise && bit_q == 4'h8 && ctl_q[0]);
	c_write: cover property (rise && bit_q == 4'h8 && !ctl_q[0]);
	c_stop: cover property (stop);
	c_foreign: cover property (bit_q == 4'h9 && ctl_q[7:1] != own);
endmodule

//--- bench/testbench.sv
// Self-checking bench joining the controller and device ends.
`timescale 1ns/100ps
module testbench;
	logic         CORE_CLK   = 1'h0;
	logic         SRST       = 1'h1;
	logic [127:0] resp_data  = '0;
	logic         gpo_a      = 1'h0;
	logic         gpo_b      = 1'h1;
	logic         addr_sel   = 1'h0;
	logic         req        = 1'h0;
	logic         req_read   = 1'h0;
	logic [4:0]   req_len    = 5'h01;
	logic [63:0]  wr_data    = '0;
	logic         seen_valid = 1'h0;
	logic         hung       = 1'h0;
	logic [1:0]   bus_mode;
	logic [63:0]  cmd_data;
	logic [3:0]   cmd_count;
	logic         cmd_valid;
	logic         busy;
	logic         done;
	logic [127:0] rd_data;
	logic         nacked;
	logic [31:0]  rng        = 32'h0000_169e;
	int           n_mismatch = 0;
	int           check_count = 0;
	int           lens[8]    = '{1, 8, 9, 0, 16, 1, 0, 0};

	twc_if i_twc_if ();

	twc_device i_twc_device
	(
		.CORE_CLK  (CORE_CLK),
		.SRST      (SRST),
		.PINS      (i_twc_if),
		.RESP_DATA (resp_data),
		.GPO_A     (gpo_a),
		.GPO_B     (gpo_b),
		.BUS_MODE  (bus_mode),
		.CMD_DATA  (cmd_data),
		.CMD_COUNT (cmd_count),
		.CMD_VALID (cmd_valid)
	);

	twc_controller i_twc_controller
	(
		.CORE_CLK (CORE_CLK),
		.SRST     (SRST),
		.PINS     (i_twc_if),
		.ADDR_SEL (addr_sel),
		.REQ      (req),
		.REQ_READ (req_read),
		.REQ_LEN  (req_len),
		.WR_DATA  (wr_data),
		.BUSY     (busy),
		.DONE     (done),
		.RD_DATA  (rd_data),
		.NACKED   (nacked)
	);

	twc_properties i_twc_properties
	(
		.CORE_CLK           (CORE_CLK),
		.SRST               (SRST),
		.chip_reset_n       (i_twc_if.chip_reset_n),
		.serial_clock_pin   (i_twc_if.serial_clock_pin),
		.serial_data_pin    (i_twc_if.serial_data_pin),
		.sda_d_o            (i_twc_if.sda_d_o),
		.sda_d_oe           (i_twc_if.sda_d_oe),
		.strap_a_d_oe       (i_twc_if.strap_a_d_oe),
		.strap_b_d_oe       (i_twc_if.strap_b_d_oe),
		.address_select_pin (i_twc_if.address_select_pin)
	);

	// Clock of 10 ns period.
	always #5 CORE_CLK = ~CORE_CLK;

	// Remembers a finished write; a new request clears it.
	always @(posedge CORE_CLK)
	begin
		if (req)
			seen_valid <= 1'h0;
		else if (cmd_valid === 1'h1)
			seen_valid <= 1'h1;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	// Keeps the first n bytes, which sit at the top of the wide buses.
	function automatic logic [127:0] top_bytes(input logic [127:0] v,
		input int n);
		return v & ~({128{1'h1}} >> (8 * n));
	endfunction

	task automatic check_bit(input logic act, input logic exp,
		input string what);
		check_count++;
		if (act !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	task automatic check_bytes(input logic [127:0] act,
		input logic [127:0] exp, input string what);
		check_count++;
		if (act !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// A wait that runs out counts as a mismatch; before the foreign test it also stops further tests.
	task automatic timed_out(input string what);
		n_mismatch++;
		hung = 1'h1;
		$display("wrong value at %0t: %s", $time, what);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Waits for the link reset to lift, then checks mode and strap outputs.
	task automatic reset_checks();
		int i;
		for (i = 0; i < 200 && i_twc_if.chip_reset_n !== 1'h1; i++)
			@(negedge CORE_CLK);
		if (i_twc_if.chip_reset_n !== 1'h1)
			timed_out("no reset release");
		repeat (10) @(negedge CORE_CLK);
		check_bytes(128'(bus_mode), 128'(twc_pkg::TWC_MODE_TWO_WIRE),
			"bus mode");
		check_bit(i_twc_if.mode_strap_a_out, gpo_a, "strap a");
		check_bit(i_twc_if.mode_strap_b_irq, gpo_b, "strap b");
	endtask

	// One whole transaction; REQ stays up until the controller is busy.
	// With flip set the select pin turns over once the request is taken.
	task automatic run(input logic rd, input int len, input logic sel,
		input logic flip);
		int i;
		@(posedge CORE_CLK);
		rng = xorshift(rng);
		addr_sel <= sel;
		req_read <= rd;
		req_len <= 5'(len);
		wr_data <= {rng, ~rng};
		resp_data <= {rng, ~rng, rng[15:0], rng[31:16], rng[7:0], rng[31:8]};
		gpo_a <= rng[3];
		gpo_b <= rng[4];
		req <= 1'h1;
		for (i = 0; i < 200 && busy !== 1'h1; i++)
			@(negedge CORE_CLK);
		if (busy !== 1'h1)
			timed_out("request not taken");
		@(posedge CORE_CLK);
		req <= 1'h0;
		if (flip)
			addr_sel <= !sel;
		for (i = 0; i < 40000 && done !== 1'h1; i++)
			@(negedge CORE_CLK);
		if (done !== 1'h1)
			timed_out("no completion");
		repeat (20) @(negedge CORE_CLK);
	endtask

	// Writes of one, eight and nine bytes, reads of sixteen and one, randoms.
	initial
	begin
		int k;
		int len;
		int n;
		logic rd;
		repeat (5) @(posedge CORE_CLK);
		SRST <= 1'h0;
		reset_checks();
		for (k = 0; k < 8 && !hung; k++)
		begin
			rng = xorshift(rng);
			rd = k >= 4;
			len = lens[k] != 0 ? lens[k] : 1 + int'(rng[1:0]);
			n = len > 8 ? 8 : len;
			run(rd, len, k[0], 1'h0);
			if (rd)
			begin
				check_bytes(top_bytes(rd_data, len), top_bytes(resp_data, len),
					"read bytes");
				check_bit(nacked, 1'h0, "read refused");
			end
			else
			begin
				check_bit(nacked, 1'(len > 8), "write ack");
				check_bytes(128'(cmd_count), 128'(n), "count");
				check_bytes(top_bytes({cmd_data, 64'h0}, n),
					top_bytes({wr_data, 64'h0}, n), "write bytes");
				check_bit(seen_valid, 1'h1, "write done");
			end
			$display("test %0d done, read %0d length %0d", k, rd, len);
		end
		if (!hung)
		begin
			run(1'h0, 2, 1'h0, 1'h1);
			check_bit(nacked, 1'h1, "foreign address");
			check_bit(seen_valid, 1'h0, "foreign write");
			$display("test foreign done");
			@(posedge CORE_CLK);
			SRST <= 1'h1;
			repeat (2) @(posedge CORE_CLK);
			SRST <= 1'h0;
			reset_checks();
			run(1'h0, 2, 1'h1, 1'h0);
			check_bytes(128'(cmd_count), 128'(2), "count after reset");
			$display("test reset done");
		end
		final_report();
	end
endmodule
